// >>> rtl/dmx_pkg.sv
/*
  dmx_pkg: shared constants and carrier types for the data-move execution
  block. Assumes a single 100 MHz core clock and a synchronous reset.
*/
package dmx_pkg;
  // operation codes presented by the decoder
  typedef enum logic [2:0] {
    DMX_OP_NONE     = 3'h0,
    DMX_OP_COPYF    = 3'h1,  // copy_file_op
    DMX_OP_INDLOAD  = 3'h2,  // indirect_load_op
    DMX_OP_BANKLIT  = 3'h3,  // bank_literal_op
    DMX_OP_LATCHLIT = 3'h4,  // latch_literal_op
    DMX_OP_WORKLIT  = 3'h5,  // working_literal_op
    DMX_OP_STOREW   = 3'h6   // store_working_op
  } dmx_op_t;

  // pointer_update_field encodings
  localparam logic [1:0] DMX_MM_PREINC  = 2'h0;
  localparam logic [1:0] DMX_MM_PREDEC  = 2'h1;
  localparam logic [1:0] DMX_MM_POSTINC = 2'h2;
  localparam logic [1:0] DMX_MM_POSTDEC = 2'h3;

  // widths and reset values
  localparam int          DMX_PTR_W      = 16;
  localparam int          DMX_BANK_W     = 5;
  localparam int          DMX_LATCH_W    = 7;
  localparam logic [7:0]  DMX_W_RST      = 8'h00;
  localparam logic [15:0] DMX_PTR_RST    = 16'h0000;
  localparam logic [4:0]  DMX_BANK_RST   = 5'h00;
  localparam logic [6:0]  DMX_LATCH_RST  = 7'h00;
  localparam logic        DMX_Z_RST      = 1'b0;   // zero flag after reset

  // one decoded instruction
  typedef struct packed {
    dmx_op_t     op;       // operation
    logic [6:0]  faddr;    // file register address
    logic        dest;     // 0: working reg, 1: file reg
    logic        ptr_sel;  // which pointer_reg
    logic        rel;      // 1: relative offset form
    logic [1:0]  mm;       // pointer_update_field
    logic [5:0]  offset;   // signed -32..31
    logic [7:0]  literal;  // immediate
  } dmx_instr_t;

  // memory write request toward the file
  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } dmx_fwr_t;
endpackage : dmx_pkg

// >>> rtl/dmx_exec.sv
/*
  dmx_exec: executes the data-move group of an 8-bit core, one instruction
  per enabled cycle. Assumes the surrounding core supplies file and indirect
  read data combinationally for the addresses this block drives out.
*/
`timescale 1ns/10ps
module dmx_exec #(
  // widths; only the documented ones are served by the logic below
  parameter int PTR_W   = dmx_pkg::DMX_PTR_W,    // pointer_reg width
  parameter int BANK_W  = dmx_pkg::DMX_BANK_W,   // bank_select_reg width
  parameter int LATCH_W = dmx_pkg::DMX_LATCH_W   // pc_high_latch width
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // decoded instruction
  input  wire logic               instr_valid,
  input  wire dmx_pkg::dmx_instr_t instr,
  // file register read port, combinational
  output logic [6:0]              file_raddr,
  input  wire logic [7:0]         file_rdata,
  // indirect memory read port, combinational
  output logic [PTR_W-1:0]        ind_raddr,
  input  wire logic [7:0]         ind_rdata,
  // results, all registered
  output dmx_pkg::dmx_fwr_t       file_wr,
  output logic [7:0]              work_reg,
  output logic                    zero_flag,
  output logic [PTR_W-1:0]        pointer0,
  output logic [PTR_W-1:0]        pointer1,
  output logic [BANK_W-1:0]       bank_select_reg,
  output logic [LATCH_W-1:0]      pc_high_latch
);
  logic [PTR_W-1:0] ptr_cur;      // selected pointer
  logic [PTR_W-1:0] ptr_inc;      // pointer plus one
  logic [PTR_W-1:0] ptr_dec;      // pointer minus one
  logic [PTR_W-1:0] ptr_rel;      // pointer plus signed offset
  logic [PTR_W-1:0] ptr_after;    // pointer value after the load
  logic             is_copy;      // copy_file_op this cycle
  logic             is_ind;       // indirect_load_op this cycle
  logic [7:0]       moved;        // value moved by zero-affecting ops

  // refuse widths the address and literal paths were not built for;
  // the wrap rule ties the pointer to exactly sixteen bits
  if (PTR_W != dmx_pkg::DMX_PTR_W || BANK_W != dmx_pkg::DMX_BANK_W
      || LATCH_W != dmx_pkg::DMX_LATCH_W) begin : g_width_check
    $error("dmx_exec: unsupported width parameter");
  end

  // address generation; 16-bit truncation gives wrap-around for free
  always_comb begin
    ptr_cur = instr.ptr_sel ? pointer1 : pointer0;
    ptr_inc = ptr_cur + 16'h0001;
    ptr_dec = ptr_cur - 16'h0001;
    ptr_rel = ptr_cur + {{10{instr.offset[5]}}, instr.offset};
    is_copy = instr_valid && (instr.op == dmx_pkg::DMX_OP_COPYF);
    is_ind  = instr_valid && (instr.op == dmx_pkg::DMX_OP_INDLOAD);
    file_raddr = instr.faddr;
    // effective address: pre forms step first, post forms use pointer
    if (instr.rel) begin
      ind_raddr = ptr_rel;
    end else begin
      case (instr.mm)
        dmx_pkg::DMX_MM_PREINC:  ind_raddr = ptr_inc;
        dmx_pkg::DMX_MM_PREDEC:  ind_raddr = ptr_dec;
        default:                 ind_raddr = ptr_cur;
      endcase
    end
    // pointer update: relative form leaves it alone
    if (instr.rel) begin
      ptr_after = ptr_cur;
    end else if (instr.mm[0]) begin
      ptr_after = ptr_dec;
    end else begin
      ptr_after = ptr_inc;
    end
    moved = is_ind ? ind_rdata : file_rdata;
  end

  // working register
  always_ff @(posedge clk) begin
    if (rst) begin
      work_reg <= dmx_pkg::DMX_W_RST;
    end else if (is_ind) begin
      work_reg <= ind_rdata;
    end else if (is_copy && !instr.dest) begin
      work_reg <= file_rdata;
    end else if (instr_valid && instr.op == dmx_pkg::DMX_OP_WORKLIT) begin
      work_reg <= instr.literal;
    end
  end

  // zero flag: only the moved data value matters, pointer steps never do
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_flag <= dmx_pkg::DMX_Z_RST;
    end else if (is_copy || is_ind) begin
      zero_flag <= (moved == 8'h00);
    end
  end

  // pointer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pointer0 <= dmx_pkg::DMX_PTR_RST;
      pointer1 <= dmx_pkg::DMX_PTR_RST;
    end else if (is_ind) begin
      if (instr.ptr_sel) begin
        pointer1 <= ptr_after;
      end else begin
        pointer0 <= ptr_after;
      end
    end
  end

  // bank select; only sixteen banks are reachable, so the top bit is
  // always written zero even when a wider literal arrives
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_select_reg <= dmx_pkg::DMX_BANK_RST;
    end else if (instr_valid && instr.op == dmx_pkg::DMX_OP_BANKLIT) begin
      bank_select_reg <= {1'b0, instr.literal[3:0]};
    end
  end

  // pc high latch; literal bit 7 is dropped on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_high_latch <= dmx_pkg::DMX_LATCH_RST;
    end else if (instr_valid && instr.op == dmx_pkg::DMX_OP_LATCHLIT) begin
      pc_high_latch <= instr.literal[6:0];
    end
  end

  // file write port: store working, or copy back to the same register
  always_ff @(posedge clk) begin
    if (rst) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= (instr_valid && instr.op == dmx_pkg::DMX_OP_STOREW)
                      || (is_copy && instr.dest);
      file_wr.addr <= instr.faddr;
      // a copy onto itself writes the read value back
      file_wr.data <= is_copy ? file_rdata : work_reg;
    end
  end

  // checks
  a_copy_to_work: assert property (@(posedge clk) disable iff (rst)
    is_copy && !instr.dest |=> work_reg == $past(file_rdata))
    else $error("copy to working register lost");
  a_copy_zero: assert property (@(posedge clk) disable iff (rst)
    is_copy |=> zero_flag == ($past(file_rdata) == 8'h00))
    else $error("copy zero flag wrong");
  a_ind_load: assert property (@(posedge clk) disable iff (rst)
    is_ind
    |=> work_reg == $past(ind_rdata) && zero_flag == ($past(ind_rdata) == 8'h00))
    else $error("indirect load wrong");
  a_preinc_addr: assert property (@(posedge clk) disable iff (rst)
    is_ind && !instr.rel && instr.mm == 2'h0 |-> ind_raddr == ptr_cur + 16'h0001)
    else $error("preincrement address wrong");
  a_rel_addr: assert property (@(posedge clk) disable iff (rst)
    is_ind && instr.rel && instr.offset == 6'h20 |-> ind_raddr == ptr_cur - 16'h0020)
    else $error("relative address wrong");
  a_ptr_post: assert property (@(posedge clk) disable iff (rst)
    is_ind && !instr.ptr_sel && !instr.rel && instr.mm[0]
    |=> pointer0 == $past(pointer0) - 16'h0001)
    else $error("pointer decrement wrong");
  a_ptr_wrap: assert property (@(posedge clk) disable iff (rst)
    is_ind && !instr.ptr_sel && !instr.rel && !instr.mm[0] && pointer0 == 16'hFFFF
    |=> pointer0 == 16'h0000)
    else $error("pointer wrap wrong");
  a_bank_load: assert property (@(posedge clk) disable iff (rst)
    instr_valid && instr.op == dmx_pkg::DMX_OP_BANKLIT
    |=> bank_select_reg == {1'b0, $past(instr.literal[3:0])} && $stable(zero_flag))
    else $error("bank literal wrong");
  a_latch_load: assert property (@(posedge clk) disable iff (rst)
    instr_valid && instr.op == dmx_pkg::DMX_OP_LATCHLIT
    |=> pc_high_latch == $past(instr.literal[6:0]) && $stable(zero_flag))
    else $error("latch literal wrong");
  a_work_lit: assert property (@(posedge clk) disable iff (rst)
    instr_valid && instr.op == dmx_pkg::DMX_OP_WORKLIT
    |=> work_reg == $past(instr.literal) && $stable(zero_flag))
    else $error("working literal wrong");
  a_store_work: assert property (@(posedge clk) disable iff (rst)
    instr_valid && instr.op == dmx_pkg::DMX_OP_STOREW
    |=> file_wr.we && file_wr.data == $past(work_reg) && $stable(zero_flag))
    else $error("store working wrong");
  a_flags_quiet: assert property (@(posedge clk) disable iff (rst)
    !(is_copy || is_ind) |=> $stable(zero_flag))
    else $error("zero flag changed unexpectedly");
  c_copy_self: cover property (@(posedge clk) is_copy && instr.dest);
  c_ind_rel: cover property (@(posedge clk) is_ind && instr.rel);
  c_ind_wrap: cover property (@(posedge clk) is_ind && ptr_cur == 16'h0000 && instr.mm[0]);

  // further checks on the copy-back path, the pointer arithmetic and the bank select top bit
  a_copy_back: assert property (@(posedge clk) disable iff (rst)
    is_copy && instr.dest
    |=> file_wr.we && file_wr.data == $past(file_rdata) && $stable(work_reg))
    else $error("copy back to file wrong");
  a_predec_addr: assert property (@(posedge clk) disable iff (rst)
    is_ind && !instr.rel && instr.mm == dmx_pkg::DMX_MM_PREDEC
    |-> ind_raddr == ptr_cur - 16'h0001)
    else $error("predecrement address wrong");
  a_post_addr: assert property (@(posedge clk) disable iff (rst)
    is_ind && !instr.rel && instr.mm[1] |-> ind_raddr == ptr_cur)
    else $error("post form address wrong");
  a_ptr_step_up: assert property (@(posedge clk) disable iff (rst)
    is_ind && !instr.ptr_sel && !instr.rel && !instr.mm[0]
    |=> pointer0 == $past(pointer0) + 16'h0001)
    else $error("pointer increment wrong");
  a_rel_hold: assert property (@(posedge clk) disable iff (rst)
    is_ind && instr.rel |=> $stable(pointer0) && $stable(pointer1))
    else $error("relative form moved a pointer");
  a_bank_top_bit: assert property (@(posedge clk) disable iff (rst)
    instr_valid && instr.op == dmx_pkg::DMX_OP_BANKLIT
    |=> !bank_select_reg[4])
    else $error("bank select top bit set");

  // store and upward wrap are the remaining main scenarios
  c_store_work: cover property (@(posedge clk)
    instr_valid && instr.op == dmx_pkg::DMX_OP_STOREW);
  c_ind_wrap_up: cover property (@(posedge clk)
    is_ind && ptr_cur == 16'hFFFF && !instr.mm[0] && !instr.rel);
endmodule : dmx_exec

// >>> verif/dmx_exec_tb_top.sv
/*
  dmx_exec_tb_top: self-checking bench for the data-move execution block.
  Assumes dmx_pkg and dmx_exec are compiled first; the bench plays the
  file and indirect memories itself, combinationally.
*/
`timescale 1ns/10ps
module dmx_exec_tb_top;
  logic                clk;          // core clock
  logic                rst;          // synchronous reset
  logic                instr_valid;  // instruction strobe
  dmx_pkg::dmx_instr_t instr;        // decoded instruction
  logic [6:0]          file_raddr;   // file read address
  logic [7:0]          file_rdata;   // file read data
  logic [15:0]         ind_raddr;    // effective indirect address
  logic [7:0]          ind_rdata;    // indirect read data
  dmx_pkg::dmx_fwr_t   file_wr;      // file write request
  logic [7:0]          work_reg;     // working register
  logic                zero_flag;    // zero flag
  logic [15:0]         pointer0;     // pointer_reg 0
  logic [15:0]         pointer1;     // pointer_reg 1
  logic [4:0]          bank_select_reg;
  logic [6:0]          pc_high_latch;
  logic [7:0]          fmem [128];   // file register model
  logic [15:0]         exp_p [2];    // expected pointers
  logic [7:0]          exp_w;        // expected working value
  logic                exp_z;        // expected zero flag
  logic [15:0]         last_ia;      // address seen in the issue cycle
  int                  n_mismatch;
  int                  n_checks;
  int                  cycles;

  dmx_exec i_dmx_exec (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .ind_raddr(ind_raddr),
    .ind_rdata(ind_rdata), .file_wr(file_wr), .work_reg(work_reg), .zero_flag(zero_flag),
    .pointer0(pointer0), .pointer1(pointer1), .bank_select_reg(bank_select_reg),
    .pc_high_latch(pc_high_latch));

  // folded address as data: zero only where both bytes match, e.g. 0000h, FFFFh
  assign ind_rdata = ind_raddr[15:8] ^ ind_raddr[7:0];
  assign file_rdata = fmem[file_raddr];

  always #5 clk = ~clk;

  // writes land in the model so later copies read them back
  always @(posedge clk) begin
    if (file_wr.we) fmem[file_wr.addr] <= file_wr.data;
  end

  // hang guard, far above the roughly 35 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function dmx_pkg::dmx_instr_t mk(input dmx_pkg::dmx_op_t op, input logic [6:0] fa,
      input logic d, input logic s, input logic r, input logic [1:0] m,
      input logic [5:0] k, input logic [7:0] lit);
    return '{op, fa, d, s, r, m, k, lit};
  endfunction : mk

  // issue at the falling edge; valid stays up so calls run back to back
  task do_op(input dmx_pkg::dmx_instr_t i);
    @(negedge clk);
    instr = i;
    instr_valid = 1'b1;
    #1 last_ia = ind_raddr;
    @(posedge clk);
    #1;
  endtask : do_op

  task chk_state;
    chk(work_reg, exp_w);
    chk(zero_flag, exp_z);
    chk(pointer0, exp_p[0]);
    chk(pointer1, exp_p[1]);
  endtask : chk_state

  // one indirect load with its expected address, data and pointer step
  task ind(input logic s, input logic r, input logic [1:0] m, input logic [5:0] k);
    logic [15:0] base;
    logic [15:0] ea;
    base = exp_p[s];
    if (r) ea = base + {{10{k[5]}}, k};
    else if (m[1]) ea = base;
    else ea = m[0] ? base - 16'h0001 : base + 16'h0001;
    if (!r) exp_p[s] = m[0] ? base - 16'h0001 : base + 16'h0001;
    exp_w = ea[15:8] ^ ea[7:0];
    exp_z = (exp_w == 8'h00);
    do_op(mk(dmx_pkg::DMX_OP_INDLOAD, 7'h00, 1'b0, s, r, m, k, 8'h00));
    chk(last_ia, ea);
    chk_state();
  endtask : ind

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    n_mismatch = 0;
    n_checks = 0;
    cycles = 0;
    exp_p = '{16'h0000, 16'h0000};
    exp_w = 8'h00;
    exp_z = 1'b0;
    foreach (fmem[a]) fmem[a] = 8'(a);
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk_state();
    chk({bank_select_reg, pc_high_latch, file_wr.we}, 16'h0000);
    $display("test reset done");
    // literals never touch the zero flag, even a zero literal
    do_op(mk(dmx_pkg::DMX_OP_WORKLIT, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00));
    chk_state();
    do_op(mk(dmx_pkg::DMX_OP_BANKLIT, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h0F));
    chk(bank_select_reg, 5'h0F);
    do_op(mk(dmx_pkg::DMX_OP_LATCHLIT, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h7F));
    chk(pc_high_latch, 7'h7F);
    do_op(mk(dmx_pkg::DMX_OP_BANKLIT, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h15));
    chk(bank_select_reg, 5'h05);
    do_op(mk(dmx_pkg::DMX_OP_WORKLIT, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'hC3));
    exp_w = 8'hC3;
    chk_state();
    do_op(mk(dmx_pkg::DMX_OP_STOREW, 7'h7F, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00));
    chk({file_wr.we, file_wr.addr, file_wr.data}, 16'hFFC3);
    chk_state();
    // copies: from a zero register into working, then onto itself
    do_op(mk(dmx_pkg::DMX_OP_COPYF, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00));
    exp_w = 8'h00;
    exp_z = 1'b1;
    chk_state();
    do_op(mk(dmx_pkg::DMX_OP_COPYF, 7'h7F, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 8'h00));
    exp_z = 1'b0;
    chk({file_wr.we, file_wr.addr, file_wr.data}, 16'hFFC3);
    chk_state();
    $display("test literal and copy done");
    // all four update modes, then both wraps and the signed offset ends
    for (int m = 0; m < 4; m++) ind(1'b0, 1'b0, m[1:0], 6'h00);
    ind(1'b0, 1'b0, 2'h3, 6'h00);
    ind(1'b0, 1'b0, 2'h0, 6'h00);
    ind(1'b1, 1'b0, 2'h1, 6'h00);
    ind(1'b1, 1'b1, 2'h3, 6'h20);
    ind(1'b1, 1'b1, 2'h0, 6'h1F);
    $display("test indirect done");
    do_op(mk(dmx_pkg::DMX_OP_NONE, 7'h05, 1'b1, 1'b1, 1'b0, 2'h0, 6'h00, 8'hFF));
    chk_state();
    chk(file_wr.we, 1'b0);
    @(negedge clk);
    instr_valid = 1'b0;
    $display("test idle done");
    finish_test();
  end
endmodule : dmx_exec_tb_top
